// [hdl/slab_pkg.sv]
// Package of offsets, field positions and reset values for the alarm status bank
package slab_pkg;
  localparam logic [11:0] ADDR_STATUS = 12'h2C1;
  localparam logic [11:0] ADDR_MASK = 12'h2C2;
  localparam logic [11:0] ADDR_LANE = 12'h2C4;
  localparam logic [11:0] ADDR_SUMMARY = 12'h2C0;
  localparam int BIT_FIFO = 5;
  localparam int BIT_PLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_RSVD = 1;
  localparam int BIT_CLK = 0;
  localparam logic [7:0] STATUS_RESET = 8'h3F;
  localparam logic [7:0] MASK_RESET = 8'h3F;
  localparam logic [7:0] LANE_RESET = 8'hFF;
  localparam logic [7:0] STATUS_IMPL = 8'h3D;
  localparam logic [7:0] STATUS_READ = 8'h3F;
  localparam logic [7:0] MASK_RO_BITS = 8'h02;
  localparam int NUM_LANES = 8;
endpackage : slab_pkg

// [hdl/slab_w1c.sv]
// Sticky flag with write-one-to-clear, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module slab_w1c #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flag_o
);
  logic [WIDTH-1:0] flag_next;

  always_comb begin
    flag_next = (flag_o & ~clr_i) | set_i;
    if (soft_rst_i) begin
      flag_next = RESET_VALUE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= RESET_VALUE;
    end else begin
      flag_o <= flag_next;
    end
  end
endmodule : slab_w1c
`default_nettype wire

// [hdl/slab_bank.sv]
// Alarm status, mask and per-lane buffer alarm register bank
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Any active lane buffer overflow or underflow sets status bit 5, cleared by writing one.
// - An unlocked serializer PLL sets status bit 4, cleared by writing one.
// - In 8B/10B mode an enabled link outside data transmission sets status bit 3.
// - In 64B/66B mode link start and any forced realignment set status bit 3.
// - A SYSREF realignment of internal clocks sets status bit 2, cleared by writing one.
// - A divider mismatch between channel pairs AB and CD sets status bit 0.
// - Power-on or soft reset sets all alarm bits so status reads 0x3F.
// - With the link disabled only the clock upset flag is meaningful; software clears after enable.
// - Mask bits 5,4,3,2,0 keep their alarms from the summary bit and reset to masked.
// - The per-lane alarm register sets bit i on an active lane i buffer fault and resets to 0xFF.
// - Writing one clears a per-lane bit, which may set again the next cycle.
// - Writing one to status bit 5 clears every per-lane alarm bit.
// - The summary bit is one when any unmasked status alarm is set, also driven on a pin.
module slab_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic serial_link_enable_i,
  input wire logic mode_64b66b_i,
  input wire logic [7:0] lane_active_i,
  input wire logic [7:0] lane_fault_i,
  input wire logic pll_locked_i,
  input wire logic data_transmission_state_i,
  input wire logic link_start_i,
  input wire logic realign_force_i,
  input wire logic sysref_realign_i,
  input wire logic [3:0] div_ab_i,
  input wire logic [3:0] div_cd_i,
  output logic summary_alarm_o,
  output logic status_output_pin_o
);
  logic [7:0] lane_sync1_reg;
  logic [7:0] lane_sync2_reg;
  logic pll_sync1_reg;
  logic pll_sync2_reg;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] status_flags;
  logic [7:0] lane_set;
  logic [7:0] lane_clr;
  logic [7:0] lane_flags;
  logic status_wr;
  logic lane_wr;
  logic summary_next;

  // Fault pulses from other clock regions pass two flops first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lane_sync1_reg <= 8'h00;
      lane_sync2_reg <= 8'h00;
      pll_sync1_reg <= 1'b0;
      pll_sync2_reg <= 1'b0;
    end else begin
      lane_sync1_reg <= lane_fault_i;
      lane_sync2_reg <= lane_sync1_reg;
      pll_sync1_reg <= pll_locked_i;
      pll_sync2_reg <= pll_sync1_reg;
    end
  end

  always_comb begin
    status_wr = 1'b0;
    lane_wr = 1'b0;
    if (wr_i && addr_i == slab_pkg::ADDR_STATUS) begin
      status_wr = 1'b1;
    end else if (wr_i && addr_i == slab_pkg::ADDR_LANE) begin
      lane_wr = 1'b1;
    end
  end

  always_comb begin
    lane_set = lane_sync2_reg & lane_active_i;
    status_set = 8'h00;
    status_set[slab_pkg::BIT_FIFO] = |lane_set;
    status_set[slab_pkg::BIT_PLL] = ~pll_sync2_reg;
    // Undefined while disabled; software clears after enabling
    if (mode_64b66b_i) begin
      status_set[slab_pkg::BIT_LINK] = link_start_i | realign_force_i;
    end else begin
      status_set[slab_pkg::BIT_LINK] = serial_link_enable_i
        & ~data_transmission_state_i;
    end
    status_set[slab_pkg::BIT_REALIGN] = sysref_realign_i;
    status_set[slab_pkg::BIT_CLK] = (div_ab_i != div_cd_i);
    status_clr = status_wr ? (wdata_i & slab_pkg::STATUS_IMPL) : 8'h00;
    lane_clr = lane_wr ? wdata_i : 8'h00;
    if (status_wr && wdata_i[slab_pkg::BIT_FIFO]) begin
      lane_clr = 8'hFF;
    end
  end

  slab_w1c #(
    .WIDTH(8),
    .RESET_VALUE(slab_pkg::STATUS_RESET)
  ) u_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .set_i(status_set),
    .clr_i(status_clr),
    .flag_o(status_flags)
  );

  slab_w1c #(
    .WIDTH(8),
    .RESET_VALUE(slab_pkg::LANE_RESET)
  ) u_lane (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .set_i(lane_set),
    .clr_i(lane_clr),
    .flag_o(lane_flags)
  );

  // Reserved bit 1 stays one so a careless write cannot unmask nothing
  always_comb begin
    mask_next = mask_reg;
    if (wr_i && addr_i == slab_pkg::ADDR_MASK) begin
      mask_next = (wdata_i & slab_pkg::STATUS_IMPL) | slab_pkg::MASK_RO_BITS;
    end
    if (soft_rst_i) begin
      mask_next = slab_pkg::MASK_RESET;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= slab_pkg::MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign summary_next = |(status_flags & ~mask_reg & slab_pkg::STATUS_IMPL);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      summary_alarm_o <= 1'b0;
      status_output_pin_o <= 1'b0;
    end else begin
      summary_alarm_o <= summary_next;
      status_output_pin_o <= summary_next;
    end
  end

  // Registered read data, one cycle after rd_i
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == slab_pkg::ADDR_STATUS) begin
        rdata_o <= status_flags & slab_pkg::STATUS_READ;
      end else if (addr_i == slab_pkg::ADDR_MASK) begin
        rdata_o <= mask_reg;
      end else if (addr_i == slab_pkg::ADDR_LANE) begin
        rdata_o <= lane_flags;
      end else if (addr_i == slab_pkg::ADDR_SUMMARY) begin
        rdata_o <= {7'h00, summary_next};
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // Fault seen and let through, then the summary flop one edge later
  sequence s_lane_fault_open;
    status_flags[slab_pkg::BIT_FIFO] && !mask_reg[slab_pkg::BIT_FIFO];
  endsequence

  sequence s_all_inhibited;
    (mask_reg & slab_pkg::STATUS_IMPL) == slab_pkg::STATUS_IMPL;
  endsequence

  a_fifo_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (|lane_set) |=> status_flags[slab_pkg::BIT_FIFO])
    else $error("lane fault did not set flag");
  a_pll_set: assert property (@(posedge clk_i) disable iff (rst_i)
    !pll_sync2_reg |=> status_flags[slab_pkg::BIT_PLL])
    else $error("pll loss not flagged");
  a_link_8b: assert property (@(posedge clk_i) disable iff (rst_i)
    (!mode_64b66b_i && serial_link_enable_i && !data_transmission_state_i)
    |=> status_flags[slab_pkg::BIT_LINK])
    else $error("link fault not flagged");
  a_link_64b: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_64b66b_i && (link_start_i || realign_force_i)) |=> status_flags[slab_pkg::BIT_LINK])
    else $error("64b link fault not flagged");
  a_realign_set: assert property (@(posedge clk_i) disable iff (rst_i)
    sysref_realign_i |=> status_flags[slab_pkg::BIT_REALIGN])
    else $error("realign not flagged");
  a_clk_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (div_ab_i != div_cd_i) |=> status_flags[slab_pkg::BIT_CLK])
    else $error("clock upset missed");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_rst_i |=> ((status_flags & slab_pkg::STATUS_READ) == slab_pkg::STATUS_RESET
    && lane_flags == slab_pkg::LANE_RESET && mask_reg == slab_pkg::MASK_RESET))
    else $error("soft reset values wrong");
  a_lane_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_wr && wdata_i[slab_pkg::BIT_FIFO] && !soft_rst_i) |=> (lane_flags == $past(lane_set)))
    else $error("lane flags not cleared");
  a_w1c_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (lane_wr && !soft_rst_i && !status_wr) |=> (lane_flags ==
    (($past(lane_flags) & ~$past(wdata_i)) | $past(lane_set))))
    else $error("lane write one clear wrong");
  a_summary_out: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (summary_alarm_o == $past(summary_next)) && (status_output_pin_o == summary_alarm_o))
    else $error("summary output wrong");
  a_summary_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lane_fault_open |=> summary_alarm_o)
    else $error("unmasked fault missed summary");
  a_mask_silence: assert property (@(posedge clk_i) disable iff (rst_i)
    s_all_inhibited |=> !summary_alarm_o)
    else $error("masked alarm reached summary");
  a_mask_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == slab_pkg::ADDR_MASK && !soft_rst_i)
    |=> (mask_reg[7:6] == 2'h0 && mask_reg[slab_pkg::BIT_RSVD]))
    else $error("mask reserved bits wrong");
endmodule : slab_bank
`default_nettype wire

// [verif/test_serial_link_alarm_status_bank.sv]
// Self-checking random bench for the alarm status bank
`timescale 1ns/100ps
`default_nettype none
module test_serial_link_alarm_status_bank;
  logic clk_i = 1'h0, rst_i = 1'h1, srst = 1'h0, wr = 1'h0, rd = 1'h0, en = 1'h1, m64 = 1'h0;
  logic pll = 1'h1, dts = 1'h1, lst = 1'h0, rfc = 1'h0, syr = 1'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wd = 8'h00, act = 8'hFF, flt = 8'h00, rdv, eb, pat;
  logic [3:0] dab = 4'h0, dcd = 4'h0;
  logic [7:0] rdata;
  logic sum, pin;
  int num_errors = 0, checks_done = 0, ev, n;
  slab_bank i_slab_bank (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(srst), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wd), .rdata_o(rdata), .serial_link_enable_i(en), .mode_64b66b_i(m64),
    .lane_active_i(act), .lane_fault_i(flt), .pll_locked_i(pll), .data_transmission_state_i(dts),
    .link_start_i(lst), .realign_force_i(rfc), .sysref_realign_i(syr), .div_ab_i(dab),
    .div_cd_i(dcd), .summary_alarm_o(sum), .status_output_pin_o(pin));
  always #2 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    wr = 1'h1;
    addr = a;
    wd = d;
    @(posedge clk_i) #1;
    wr = 1'h0;
  endtask : wreg
  task automatic rreg(input logic [11:0] a);
    @(posedge clk_i) #1;
    rd = 1'h1;
    addr = a;
    @(posedge clk_i) #1;
    rd = 1'h0;
    rdv = rdata;
  endtask : rreg
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] ebit(input int e);
    case (e)
      0: return 8'h20;
      1: return 8'h10;
      5: return 8'h04;
      6: return 8'h01;
      default: return 8'h08;
    endcase
  endfunction : ebit
  // One source pulse, held two cycles so it survives the input synchronisers
  task automatic fire(input int e, input logic [7:0] p);
    case (e)
      0: flt = p;
      1: pll = 1'h0;
      2: dts = 1'h0;
      3: {m64, lst} = 2'h3;
      4: {m64, rfc} = 2'h3;
      5: syr = 1'h1;
      default: {dab, dcd} = {p[3:0], ~p[3:0]};
    endcase
    repeat (2) @(posedge clk_i) #1;
    // Idle: locked, in data state, 8B/10B, dividers equal
    {flt, pll, dts, m64, lst, rfc, syr} = {8'h00, 6'h30};
    {dab, dcd} = 8'h00;
    repeat (4) @(posedge clk_i) #1;
  endtask : fire
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial begin
    n = $urandom(20979);
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'h0;
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv, 8'h3F);
    rreg(slab_pkg::ADDR_MASK);
    chk(rdv, 8'h3F);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'hFF);
    chk({7'h00, sum}, 8'h00);
    wreg(slab_pkg::ADDR_STATUS, 8'h20);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'h00);
    wreg(slab_pkg::ADDR_STATUS, 8'h3F);
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv & 8'h3D, 8'h00);
    wreg(slab_pkg::ADDR_MASK, 8'h02);
    rreg(slab_pkg::ADDR_MASK);
    chk(rdv, 8'h02);
    wreg(slab_pkg::ADDR_MASK, 8'h3F);
    wreg(12'h2C3, 8'hFF);
    rreg(12'h2C3);
    chk(rdv, 8'h00);
    $display("reset and corner test done");
    // A persisting lane fault sets again straight after its clear
    flt = 8'h81;
    repeat (4) @(posedge clk_i) #1;
    wreg(slab_pkg::ADDR_LANE, 8'h01);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'h81);
    flt = 8'h00;
    repeat (4) @(posedge clk_i) #1;
    wreg(slab_pkg::ADDR_LANE, 8'h01);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'h80);
    wreg(slab_pkg::ADDR_STATUS, 8'h20);
    // Faults on inactive lanes stay silent
    act = 8'h0F;
    flt = 8'hF0;
    repeat (4) @(posedge clk_i) #1;
    flt = 8'h00;
    repeat (4) @(posedge clk_i) #1;
    act = 8'hFF;
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv & 8'h20, 8'h00);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'h00);
    $display("lane test done");
    for (int i = 0; i < 40; i++) begin
      ev = i < 7 ? i : int'($urandom % 7);
      pat = 8'(1 + $urandom % 255);
      eb = ebit(ev);
      fire(ev, pat);
      rreg(slab_pkg::ADDR_LANE);
      chk(rdv, ev == 0 ? pat : 8'h00);
      wreg(slab_pkg::ADDR_STATUS, 8'h00);
      rreg(slab_pkg::ADDR_STATUS);
      chk(rdv & 8'h3D, eb);
      chk({7'h00, sum}, 8'h00);
      wreg(slab_pkg::ADDR_MASK, 8'h3F & ~eb);
      rreg(slab_pkg::ADDR_SUMMARY);
      chk(rdv, 8'h01);
      chk({6'h00, sum, pin}, 8'h03);
      wreg(slab_pkg::ADDR_STATUS, eb);
      rreg(slab_pkg::ADDR_STATUS);
      chk(rdv & 8'h3D, 8'h00);
      rreg(slab_pkg::ADDR_LANE);
      chk(rdv, 8'h00);
      chk({6'h00, sum, pin}, 8'h00);
      wreg(slab_pkg::ADDR_MASK, 8'h3F);
    end
    $display("random alarm test done");
    // Clock upset still counts with the link off; clear only after enabling
    en = 1'h0;
    {dab, dcd} = 8'h3C;
    repeat (2) @(posedge clk_i) #1;
    wreg(slab_pkg::ADDR_STATUS, 8'h01);
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv & 8'h01, 8'h01);
    {dab, dcd} = 8'h00;
    en = 1'h1;
    wreg(slab_pkg::ADDR_STATUS, 8'h3F);
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv & 8'h3D, 8'h00);
    $display("link off test done");
    wreg(slab_pkg::ADDR_MASK, 8'h02);
    srst = 1'h1;
    @(posedge clk_i) #1;
    srst = 1'h0;
    rreg(slab_pkg::ADDR_STATUS);
    chk(rdv, 8'h3F);
    rreg(slab_pkg::ADDR_LANE);
    chk(rdv, 8'hFF);
    rreg(slab_pkg::ADDR_MASK);
    chk(rdv, 8'h3F);
    $display("soft reset test done");
    wrap_up();
  end
endmodule : test_serial_link_alarm_status_bank
`default_nettype wire
